// ---- psg_defines.svh ----
// register offsets, field positions, reset values and timing counts of the stage guard
`ifndef PSG_DEFINES_SVH
`define PSG_DEFINES_SVH

`define PSG_ADDR_RAMP_INTERVAL 9'h007
`define PSG_ADDR_CONDITION 9'h03c
`define PSG_ADDR_RAMP_LOWER 9'h040
`define PSG_ADDR_RAMP_UPPER 9'h041
`define PSG_ADDR_RAMP_STEP 9'h042
`define PSG_ADDR_EVENT_STATUS 9'h050
`define PSG_ADDR_EVENT_MASK 9'h051
`define PSG_ADDR_VOLUME 9'h052

`define PSG_RST_RAMP_INTERVAL 16'h0000
`define PSG_RST_RAMP_LOWER 16'h0000
`define PSG_RST_RAMP_UPPER 16'h7fff
`define PSG_RST_RAMP_STEP 16'h0001
`define PSG_RST_EVENT_MASK 4'h0

`define PSG_COND_WARN_BIT 0
`define PSG_COND_FAULT_BIT 1

`define PSG_EVT_FAULT_BIT 0
`define PSG_EVT_WARN_BIT 1
`define PSG_EVT_LOWER_BIT 2
`define PSG_EVT_UPPER_BIT 3

`define PSG_STEP_CYCLES_PER_UNIT 21'h000010

`endif

// ---- psg_pkg.sv ----
// types shared by the stage guard modules
package psg_pkg;

  typedef logic [8:0] psg_addr_t;
  typedef logic [15:0] psg_word_t;
  typedef logic [3:0] psg_evt_t;

  typedef enum logic [1:0] {
    PSG_RAMP_HOLD = 2'b00,
    PSG_RAMP_DOWN = 2'b01,
    PSG_RAMP_UP = 2'b11
  } psg_ramp_t;

endpackage

// ---- psg_pin_if.sv ----
// stage input pins between the input filter and the guard core
`timescale 1ns/1ps
`default_nettype none

interface psg_pin_if;
  logic faultLowRaw;
  logic warnLowRaw;
  logic faultLow;
  logic warnLow;

  modport filt (
    input faultLowRaw,
    input warnLowRaw,
    output faultLow,
    output warnLow
  );

  modport core (
    input faultLow,
    input warnLow
  );
endinterface

`default_nettype wire

// ---- psg_input_filter.sv ----
// three-stage synchroniser and agreement filter for the stage inputs
`timescale 1ns/1ps
`default_nettype none

module psg_input_filter (
  input wire logic core_clk, // core clock
  input wire logic sys_rst, // synchronous reset, active high
  psg_pin_if.filt pins // raw pins in, filtered levels out
);
  import psg_pkg::*;

  typedef struct packed {
    logic [1:0] stage1;
    logic [1:0] stage2;
    logic [1:0] stage3;
    logic [1:0] level;
  } psg_filter_state_t;

  psg_filter_state_t st;
  psg_filter_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.stage1 = {pins.faultLowRaw, pins.warnLowRaw};
    next_st.stage2 = st.stage1;
    next_st.stage3 = st.stage2;
    for (int i = 0; i < 2; i++) begin
      if (st.stage2[i] == st.stage3[i]) begin
        next_st.level[i] = st.stage3[i];
      end
    end
    if (sys_rst) begin
      // inputs idle high: no fault, no warning
      next_st = '{stage1: 2'h3, stage2: 2'h3, stage3: 2'h3, level: 2'h3};
    end
  end

  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  assign pins.warnLow = st.level[0];
  assign pins.faultLow = st.level[1];
endmodule

`default_nettype wire

// ---- psg_stage_guard.sv ----
// power stage guard: enable pair, fault/warning handling and volume ramp
//
// Overview of operation
// - two enable outputs, always complementary
// - both enables high-impedance while reset held
// - fault low drives both enables inactive
// - fault released re-enables the stage
// - warning low ramps volume down to lower
// - warning released ramps volume up to upper
// - one step per 16*(interval+1) cycles
// - step interval register at 007h, shared
// - lower, upper, step at 040h-042h
// - live warning and fault levels readable
// - reset restores all registers to defaults
`include "psg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module psg_stage_guard (
  input wire logic core_clk, // core clock, 10 MHz
  input wire logic sys_rst, // synchronous reset, active high
  input wire psg_pkg::psg_addr_t regAddr, // register word address
  input wire psg_pkg::psg_word_t regWriteData, // register write data
  input wire logic regWrite, // write strobe
  input wire logic regRead, // read strobe
  output logic [15:0] regReadData, // read data, cycle after strobe
  input wire logic stageFaultLowIn, // stage fault pin, active low
  input wire logic stageWarningLowIn, // stage warning pin, active low
  output logic stageEnableHighOut, // enable, active high
  output logic stageEnableHighOe, // drive enable of the high-active pin
  output logic stageEnableLowOut, // enable, active low
  output logic stageEnableLowOe, // drive enable of the low-active pin
  output logic [15:0] pcmVolume, // ramped pcm volume
  output logic irq // level interrupt, high while unmasked event pending
);
  import psg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    psg_word_t rampInterval;
    psg_word_t rampLower;
    psg_word_t rampUpper;
    psg_word_t rampStep;
    psg_word_t volume;
    psg_ramp_t ramp;
    logic [20:0] prescale;
    psg_evt_t evtStatus;
    psg_evt_t evtMask;
    psg_word_t readData;
    logic irq;
    logic enHigh;
    logic enLow;
    logic enOe;
    logic faultSeen;
    logic warnSeen;
  } psg_core_state_t;

  psg_core_state_t st;
  psg_core_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // step toward the lower endpoint without passing it
  function automatic psg_word_t stepDown(psg_word_t vol, psg_word_t step, psg_word_t lower);
    logic [16:0] floorSum;
    floorSum = {1'b0, lower} + {1'b0, step};
    if ({1'b0, vol} <= floorSum) begin
      return lower;
    end
    return vol - step;
  endfunction

  // step toward the upper endpoint without passing it
  function automatic psg_word_t stepUp(psg_word_t vol, psg_word_t step, psg_word_t upper);
    logic [16:0] sum;
    sum = {1'b0, vol} + {1'b0, step};
    if (sum >= {1'b0, upper}) begin
      return upper;
    end
    return sum[15:0];
  endfunction

  // cycles between volume steps
  function automatic logic [20:0] stepPeriod(psg_word_t interval);
    logic [20:0] units;
    units = {5'h00, interval} + 21'h000001;
    return 21'(units * `PSG_STEP_CYCLES_PER_UNIT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // synchronised stage inputs

  psg_pin_if pins ();

  assign pins.faultLowRaw = stageFaultLowIn;
  assign pins.warnLowRaw = stageWarningLowIn;

  psg_input_filter inputFilter (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pins(pins)
  );

  logic faultActive;
  logic warnActive;

  assign faultActive = ~pins.faultLow;
  assign warnActive = ~pins.warnLow;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    psg_evt_t events;
    psg_word_t newVolume;
    logic stepNow;
    events = 4'h0;
    newVolume = st.volume;
    stepNow = 1'b0;
    next_st = st;

    // stage enable pair
    next_st.enOe = 1'b1;
    next_st.enHigh = ~faultActive;
    next_st.enLow = faultActive;

    // ramp direction follows the warning level
    if (warnActive) begin
      next_st.ramp = PSG_RAMP_DOWN;
    end else if (st.volume != st.rampUpper) begin
      next_st.ramp = PSG_RAMP_UP;
    end else begin
      next_st.ramp = PSG_RAMP_HOLD;
    end

    // step pacing; the count restarts when the direction changes
    if (st.ramp == PSG_RAMP_HOLD || next_st.ramp != st.ramp) begin
      next_st.prescale = 21'h000000;
    end else if (st.prescale >= stepPeriod(st.rampInterval) - 21'h000001) begin
      next_st.prescale = 21'h000000;
      stepNow = 1'b1;
    end else begin
      next_st.prescale = st.prescale + 21'h000001;
    end

    if (stepNow) begin
      case (st.ramp)
        PSG_RAMP_DOWN: begin
          newVolume = stepDown(st.volume, st.rampStep, st.rampLower);
        end
        PSG_RAMP_UP: begin
          newVolume = stepUp(st.volume, st.rampStep, st.rampUpper);
        end
        default: begin
          newVolume = st.volume;
        end
      endcase
    end
    next_st.volume = newVolume;

    // events
    next_st.faultSeen = faultActive;
    next_st.warnSeen = warnActive;
    events[`PSG_EVT_FAULT_BIT] = faultActive & ~st.faultSeen;
    events[`PSG_EVT_WARN_BIT] = warnActive & ~st.warnSeen;
    events[`PSG_EVT_LOWER_BIT] = stepNow & (st.ramp == PSG_RAMP_DOWN) &
      (newVolume == st.rampLower) & (st.volume != st.rampLower);
    events[`PSG_EVT_UPPER_BIT] = stepNow & (st.ramp == PSG_RAMP_UP) &
      (newVolume == st.rampUpper) & (st.volume != st.rampUpper);

    // register writes
    if (regWrite) begin
      case (regAddr)
        `PSG_ADDR_RAMP_INTERVAL: begin
          next_st.rampInterval = regWriteData;
        end
        `PSG_ADDR_RAMP_LOWER: begin
          next_st.rampLower = regWriteData;
        end
        `PSG_ADDR_RAMP_UPPER: begin
          next_st.rampUpper = regWriteData;
        end
        `PSG_ADDR_RAMP_STEP: begin
          next_st.rampStep = regWriteData;
        end
        `PSG_ADDR_EVENT_STATUS: begin
          next_st.evtStatus = st.evtStatus & ~regWriteData[3:0];
        end
        `PSG_ADDR_EVENT_MASK: begin
          next_st.evtMask = regWriteData[3:0];
        end
        default: begin
          next_st.evtMask = st.evtMask;
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_st.evtStatus = next_st.evtStatus | events;
    next_st.irq = |(next_st.evtStatus & next_st.evtMask);

    // register reads
    next_st.readData = 16'h0000;
    if (regRead) begin
      case (regAddr)
        `PSG_ADDR_RAMP_INTERVAL: begin
          next_st.readData = st.rampInterval;
        end
        `PSG_ADDR_RAMP_LOWER: begin
          next_st.readData = st.rampLower;
        end
        `PSG_ADDR_RAMP_UPPER: begin
          next_st.readData = st.rampUpper;
        end
        `PSG_ADDR_RAMP_STEP: begin
          next_st.readData = st.rampStep;
        end
        `PSG_ADDR_CONDITION: begin
          next_st.readData[`PSG_COND_WARN_BIT] = pins.warnLow;
          next_st.readData[`PSG_COND_FAULT_BIT] = pins.faultLow;
        end
        `PSG_ADDR_EVENT_STATUS: begin
          next_st.readData = {12'h000, st.evtStatus};
        end
        `PSG_ADDR_EVENT_MASK: begin
          next_st.readData = {12'h000, st.evtMask};
        end
        `PSG_ADDR_VOLUME: begin
          next_st.readData = st.volume;
        end
        default: begin
          next_st.readData = 16'h0000;
        end
      endcase
    end

    if (sys_rst) begin
      next_st.rampInterval = `PSG_RST_RAMP_INTERVAL;
      next_st.rampLower = `PSG_RST_RAMP_LOWER;
      next_st.rampUpper = `PSG_RST_RAMP_UPPER;
      next_st.rampStep = `PSG_RST_RAMP_STEP;
      next_st.volume = `PSG_RST_RAMP_UPPER;
      next_st.ramp = PSG_RAMP_HOLD;
      next_st.prescale = 21'h000000;
      next_st.evtStatus = 4'h0;
      next_st.evtMask = `PSG_RST_EVENT_MASK;
      next_st.readData = 16'h0000;
      next_st.irq = 1'b0;
      next_st.enHigh = 1'b0;
      next_st.enLow = 1'b1;
      next_st.enOe = 1'b0;
      next_st.faultSeen = 1'b0;
      next_st.warnSeen = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from state

  assign regReadData = st.readData;
  assign stageEnableHighOut = st.enHigh;
  assign stageEnableLowOut = st.enLow;
  assign stageEnableHighOe = st.enOe;
  assign stageEnableLowOe = st.enOe;
  assign pcmVolume = st.volume;
  assign irq = st.irq;
endmodule

`default_nettype wire

// ---- psg_stage_guard_assertions.sv ----
// port checker of the stage guard
`timescale 1ns/1ps
`default_nettype none
`include "psg_defines.svh"
module psg_stage_guard_assertions (
  input wire logic core_clk, // clock
  input wire logic sys_rst, // reset
  input wire psg_pkg::psg_addr_t regAddr, // address
  input wire psg_pkg::psg_word_t regWriteData, // write data
  input wire logic regWrite, // write strobe
  input wire logic regRead, // read strobe
  input wire logic [15:0] regReadData, // read data
  input wire logic stageFaultLowIn, // fault pin
  input wire logic stageWarningLowIn, // warning pin
  input wire logic stageEnableHighOut, // enable high
  input wire logic stageEnableHighOe, // enable high driven
  input wire logic stageEnableLowOut, // enable low
  input wire logic stageEnableLowOe, // enable low driven
  input wire logic [15:0] pcmVolume, // volume
  input wire logic irq // interrupt
);
  import psg_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  a_enable_pair_inverse: assert property (stageEnableHighOe |->
    stageEnableLowOe && stageEnableLowOut == !stageEnableHighOut) else $error("pair mismatch");
  a_reset_high_z: assert property (disable iff (1'b0) sys_rst |=>
    !stageEnableHighOe && !stageEnableLowOe) else $error("enables driven in reset");
  // pin to enable output takes five edges: three flops, filter level, enable register
  a_fault_disables: assert property (!stageFaultLowIn [*5] |=>
    !stageEnableHighOut) else $error("stage not disabled");
  a_fault_releases: assert property (stageFaultLowIn [*5] |=>
    stageEnableHighOut && stageEnableHighOe) else $error("stage not enabled");
  a_ramp_down_dir: assert property (!stageWarningLowIn [*6] ##0 $changed(pcmVolume) |->
    pcmVolume < $past(pcmVolume)) else $error("volume rose");
  a_ramp_up_dir: assert property (stageWarningLowIn [*6] ##0 $changed(pcmVolume) |->
    pcmVolume > $past(pcmVolume)) else $error("volume fell");
  a_step_spacing: assert property ($changed(pcmVolume) |=>
    $stable(pcmVolume) [*8] ##1 $stable(pcmVolume) [*7]) else $error("step too soon");
  a_condition_live: assert property (($stable(stageFaultLowIn) &&
    $stable(stageWarningLowIn)) [*5] ##0 (regRead && regAddr == `PSG_ADDR_CONDITION) |=>
    regReadData[1:0] == {$past(stageFaultLowIn), $past(stageWarningLowIn)})
    else $error("condition bits wrong");
  a_reset_outputs: assert property (disable iff (1'b0) sys_rst |=>
    pcmVolume == 16'h7fff && !irq && regReadData == 16'h0000) else $error("reset values");
endmodule
bind psg_stage_guard psg_stage_guard_assertions i_chk (.core_clk, .sys_rst, .regAddr,
  .regWriteData, .regWrite, .regRead, .regReadData, .stageFaultLowIn, .stageWarningLowIn,
  .stageEnableHighOut, .stageEnableHighOe, .stageEnableLowOut, .stageEnableLowOe,
  .pcmVolume, .irq);
`default_nettype wire

// ---- psg_stage_model.sv ----
// power stage stand-in: condition pins out, enable pins in
`timescale 1ns/1ps
`default_nettype none
module psg_stage_model (
  input wire logic faultCond, // fault present
  input wire logic warnCond, // warning present
  input wire logic enHigh, // enable high
  input wire logic enHighOe, // enable high driven
  input wire logic enLow, // enable low
  input wire logic enLowOe, // enable low driven
  output logic faultLow, // fault pin
  output logic warnLow, // warning pin
  output logic stageOn // stage running
);
  assign faultLow = !faultCond;
  assign warnLow = !warnCond;
  // a floating enable pin keeps the stage off
  assign stageOn = enHighOe && enLowOe && enHigh && !enLow;
endmodule
`default_nettype wire

// ---- psg_stage_guard_tb.sv ----
// self-checking bench of the stage guard
`timescale 1ns/1ps
`default_nettype none
`include "psg_defines.svh"
module psg_stage_guard_tb;
  import psg_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  psg_addr_t regAddr = 9'h000;
  psg_word_t regWriteData = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic faultCond = 1'b0;
  logic warnCond = 1'b0;
  logic [15:0] regReadData, pcmVolume, pinWord;
  logic stageFaultLowIn, stageWarningLowIn, stageOn, irq;
  logic stageEnableHighOut, stageEnableHighOe, stageEnableLowOut, stageEnableLowOe;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  psg_addr_t ra[8] = '{9'h007, 9'h040, 9'h041, 9'h042, 9'h050, 9'h051, 9'h052, 9'h1ff};
  logic [15:0] rv[8] = '{16'h0, 16'h0, 16'h7fff, 16'h1, 16'h0, 16'h0, 16'h7fff, 16'h0};
  logic [15:0] wv[8] = '{16'h3, 16'h123, 16'h7ffe, 16'h5, 16'hf, 16'ha, 16'h1234, 16'h1234};
  logic [15:0] ev[8] = '{16'h3, 16'h123, 16'h7ffe, 16'h5, 16'h0, 16'ha, 16'h7fff, 16'h0};
  assign pinWord = {10'h000, stageEnableHighOe, stageEnableLowOe, stageEnableHighOut,
    stageEnableLowOut, stageOn, irq};
  always #50 core_clk = ~core_clk;
  psg_stage_guard i_dut (.core_clk, .sys_rst, .regAddr, .regWriteData, .regWrite, .regRead,
    .regReadData, .stageFaultLowIn, .stageWarningLowIn, .stageEnableHighOut,
    .stageEnableHighOe, .stageEnableLowOut, .stageEnableLowOe, .pcmVolume, .irq);
  psg_stage_model i_stage (.faultCond, .warnCond, .enHigh(stageEnableHighOut),
    .enHighOe(stageEnableHighOe), .enLow(stageEnableLowOut), .enLowOe(stageEnableLowOe),
    .faultLow(stageFaultLowIn), .warnLow(stageWarningLowIn), .stageOn);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input psg_addr_t a, input psg_word_t d);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input psg_addr_t a, input logic [15:0] exp);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    chk(regReadData, exp);
    @(posedge core_clk);
  endtask
  // n counts the cycles until the volume shows v
  task automatic waitVol(input logic [15:0] v);
    n = 0;
    #1;
    while (pcmVolume !== v && n < 3000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(pcmVolume, v);
    @(posedge core_clk);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
      for (int i = 0; i < 8; i++) wr(ra[i], wv[i]);
      for (int i = 0; i < 8; i++) rd(ra[i], ev[i]);
      sys_rst <= 1'b1;
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'b0;
      #1 chk(pinWord, 16'h0004);
      @(posedge core_clk);
    end
    wr(`PSG_ADDR_EVENT_MASK, 16'h0001);
    faultCond <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 chk(pinWord, 16'h003a);
    @(posedge core_clk);
    #1 chk(pinWord, 16'h0035);
    rd(`PSG_ADDR_CONDITION, 16'h0001);
    rd(`PSG_ADDR_EVENT_STATUS, 16'h0001);
    wr(`PSG_ADDR_EVENT_STATUS, 16'h0001);
    rd(`PSG_ADDR_EVENT_STATUS, 16'h0000);
    #1 chk(pinWord, 16'h0034);
    faultCond <= 1'b0;
    repeat (5) @(posedge core_clk);
    #1 chk(pinWord, 16'h003a);
    rd(`PSG_ADDR_CONDITION, 16'h0003);
    wr(`PSG_ADDR_RAMP_STEP, 16'h4000);
    for (int iv = 0; iv < 2; iv++) begin
      wr(`PSG_ADDR_RAMP_INTERVAL, 16'(iv));
      wr(`PSG_ADDR_EVENT_STATUS, 16'h000f);
      warnCond <= 1'b1;
      waitVol(16'h3fff);
      waitVol(16'h0000);
      chk(16'(n + 1), 16'(16 * (iv + 1)));
      rd(`PSG_ADDR_EVENT_STATUS, 16'h0006);
      #1 chk(pinWord, 16'h003a);
      warnCond <= 1'b0;
      waitVol(16'h4000);
      waitVol(16'h7fff);
      chk(16'(n + 1), 16'(16 * (iv + 1)));
      rd(`PSG_ADDR_EVENT_STATUS, 16'h000e);
    end
    end_sim();
  end
endmodule
`default_nettype wire
